// ==== verilog/vfm_pkg.sv ====
// Purpose: shared constants for the valve fault monitor
// Assumes: percentages are unsigned 8-bit, 0..100 of full scale
// Notes: register indices are word addresses on the plain port
package vfm_pkg;
  localparam int PCT_W = 8;
  localparam int ADDR_W = 4;
  localparam int NUM_ALERTS = 6;
  // register addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_MISMATCH_THR = 4'h1;
  localparam logic [3:0] ADDR_MISMATCH_TIME = 4'h2;
  localparam logic [3:0] ADDR_ALERT_EN = 4'h3;
  localparam logic [3:0] ADDR_ALERT_STAT = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h6;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h7;
  localparam logic [3:0] ADDR_TARGET_MODE = 4'h8;
  localparam logic [3:0] ADDR_MODE_STAT = 4'h9;
  localparam logic [3:0] ADDR_CATEGORY = 4'hA;
  localparam logic [3:0] ADDR_NOTIFY_TIMEOUT = 4'hB;
  localparam logic [3:0] ADDR_MEASURE = 4'hC;
  // control register fields
  localparam int CTRL_TRIGGER_BIT = 0;
  localparam int CTRL_AUTO_RECOVER_BIT = 1;
  localparam int CTRL_ZP_OPEN_BIT = 2;
  // alert bit positions
  localparam int AL_MISMATCH = 0;
  localparam int AL_DRIVE = 1;
  localparam int AL_PROG_MEM = 2;
  localparam int AL_STATIC_MEM = 3;
  localparam int AL_PROC = 4;
  localparam int AL_IO_PROC = 5;
  // alerts that may trigger shutdown
  localparam logic [5:0] SHUTDOWN_MASK = 6'h2D;
  // drive-level limits, percent
  localparam logic [7:0] DRIVE_LOW_PCT = 8'h0A;
  localparam logic [7:0] DRIVE_HIGH_PCT = 8'h5A;
  localparam logic [7:0] TRAVEL_LOW_PCT = 8'h03;
  localparam logic [7:0] TRAVEL_HIGH_PCT = 8'h61;
  // reset values
  localparam logic [7:0] THR_RESET = 8'h05;
  localparam logic [15:0] TIME_RESET = 16'h0100;
  localparam logic [15:0] TIMEOUT_RESET = 16'h1000;
  localparam logic [5:0] ALERT_EN_RESET = 6'h3F;
  localparam logic [2:0] CTRL_RESET = 3'h1;
  // category encodings
  localparam logic [1:0] CAT_FAILED = 2'h0;
  localparam logic [1:0] CAT_MAINT = 2'h1;
  localparam logic [1:0] CAT_ADVISORY = 2'h2;
  typedef enum logic [1:0] {
    MODE_OOS = 2'h0,
    MODE_MAN = 2'h1,
    MODE_AUTO = 2'h2
  } vfm_mode_type;
  typedef enum {ST_RUN, ST_SHUT_AUTO, ST_SHUT_LATCH} vfm_state_type;
  typedef enum {NT_IDLE, NT_WAIT} vfm_notify_type;
endpackage

// ==== verilog/vfm_monitor.sv ====
// Purpose: fault monitor and self-test shutdown for a valve positioner
// Assumes: measured inputs already on mclk; fault inputs asynchronous
// Notes: registers on a plain strobe port, read data one cycle later
// Notes on behaviour
// - mismatch alert when |coil - drive| tops threshold past mismatch time.
// - coil current and drive both reported as percent of maximum drive.
// - zp closed: drive<10 with travel>3, or drive>90 with travel<97.
// - zero-power open: drive<10 with travel<97, or drive>90 with travel>3.
// - each alert asserts only while its enable bit is set.
// - trigger on plus shutdown-capable alert forces mode out of service.
// - while shut down, drive valve to zero power, stop control function.
// - auto recovery restores target mode once the cause clears.
// - no auto recovery: stay shut until reset or target rewritten.
// - shutdown holds while the cause persists unless trigger disabled.
// - program memory alert on pending flash/nvm failure; shutdown-capable.
// - static memory alert on parameter memory failure; shutdown-capable.
// - processor alert, gated by enable, on main processor failure.
// - io processor alert on its failure; shutdown-capable.
// - notify plant alert, await ack, resend after timeout even if cleared.
// - each plant alert reported as failed, maintenance or advisory.
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module vfm_monitor
  import vfm_pkg::*;
#(
  parameter int TIME_W = 16
) (
  input wire logic mclk, // 25 MHz clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic [3:0] reg_addr, // register address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire logic [7:0] drive_pct, // commanded drive, percent
  input wire logic [7:0] coil_pct, // measured coil current, percent
  input wire logic [7:0] travel_pct, // calibrated travel, percent
  input wire logic prog_mem_fail, // pending flash or nvm failure
  input wire logic static_mem_fail, // static parameter memory failure
  input wire logic proc_fail, // main processor failure
  input wire logic io_proc_fail, // io processor failure
  output logic zero_power_cmd, // drive valve to zero-power state
  output logic control_run, // transducer control may execute
  output logic [1:0] actual_mode, // actual transducer mode
  output logic notify_valid, // plant alert notification pulse
  output logic [5:0] notify_alerts, // alerts carried by notification
  output logic [11:0] notify_category, // 2-bit category per alert
  input wire logic notify_ack, // host acknowledgment pulse
  output logic irq // level interrupt
);

  // ==========================================================
  // helpers
  function automatic logic [7:0] abs_diff(input logic [7:0] a,
                                          input logic [7:0] b);
    abs_diff = (a > b) ? 8'(a - b) : 8'(b - a);
  endfunction

  // ==========================================================
  // fault input synchronisers
  logic [3:0] fault_s1_ff;
  logic [3:0] fault_s2_ff;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fault_s1_ff <= 4'h0;
      fault_s2_ff <= 4'h0;
    end else begin
      fault_s1_ff <= {io_proc_fail, proc_fail, static_mem_fail,
                      prog_mem_fail};
      fault_s2_ff <= fault_s1_ff;
    end
  end

  // ==========================================================
  // registers
  logic [2:0] ctrl_ff;
  logic [7:0] thr_ff;
  logic [TIME_W-1:0] mtime_ff;
  logic [5:0] alert_en_ff;
  logic [5:0] irq_stat_ff;
  logic [5:0] irq_en_ff;
  logic [1:0] target_ff;
  logic [11:0] cat_ff;
  logic [15:0] timeout_ff;
  logic [31:0] rdata_ff;
  logic target_wr_ff;

  wire wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
  wire wr_thr = reg_wr && (reg_addr == ADDR_MISMATCH_THR);
  wire wr_time = reg_wr && (reg_addr == ADDR_MISMATCH_TIME);
  wire wr_aen = reg_wr && (reg_addr == ADDR_ALERT_EN);
  wire wr_clr = reg_wr && (reg_addr == ADDR_IRQ_CLR);
  wire wr_ien = reg_wr && (reg_addr == ADDR_IRQ_EN);
  wire wr_target = reg_wr && (reg_addr == ADDR_TARGET_MODE);
  wire wr_cat = reg_wr && (reg_addr == ADDR_CATEGORY);
  wire wr_tmo = reg_wr && (reg_addr == ADDR_NOTIFY_TIMEOUT);
  // only man or auto counts as a rewrite that releases a latch
  wire target_valid = (reg_wdata[1:0] == MODE_MAN) ||
                      (reg_wdata[1:0] == MODE_AUTO);

  wire trigger_en = ctrl_ff[CTRL_TRIGGER_BIT];
  wire auto_recover = ctrl_ff[CTRL_AUTO_RECOVER_BIT];
  wire zp_open = ctrl_ff[CTRL_ZP_OPEN_BIT];

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctrl_ff <= CTRL_RESET;
      thr_ff <= THR_RESET;
      mtime_ff <= TIME_W'(TIME_RESET);
      alert_en_ff <= ALERT_EN_RESET;
      irq_en_ff <= 6'h00;
      target_ff <= MODE_AUTO;
      cat_ff <= 12'h000;
      timeout_ff <= TIMEOUT_RESET;
      target_wr_ff <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_ff <= reg_wdata[2:0];
      if (wr_thr) thr_ff <= reg_wdata[7:0];
      if (wr_time) mtime_ff <= reg_wdata[TIME_W-1:0];
      if (wr_aen) alert_en_ff <= reg_wdata[5:0];
      if (wr_ien) irq_en_ff <= reg_wdata[5:0];
      if (wr_target && target_valid) target_ff <= reg_wdata[1:0];
      if (wr_cat) cat_ff <= reg_wdata[11:0];
      if (wr_tmo) timeout_ff <= reg_wdata[15:0];
      target_wr_ff <= wr_target && target_valid;
    end
  end

  // ==========================================================
  // coil current mismatch
  logic [TIME_W-1:0] mcount_ff;
  logic mismatch_ff;
  wire over_thr = abs_diff(coil_pct, drive_pct) > thr_ff;
  wire time_done = mcount_ff >= mtime_ff;
  wire [TIME_W-1:0] nxt_mcount = !over_thr ? '0 :
                                 time_done ? mcount_ff :
                                 TIME_W'(mcount_ff + 1'b1);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mcount_ff <= '0;
      mismatch_ff <= 1'b0;
    end else begin
      mcount_ff <= nxt_mcount;
      mismatch_ff <= over_thr && time_done;
    end
  end

  // ==========================================================
  // drive level versus travel
  wire drv_low = drive_pct < DRIVE_LOW_PCT;
  wire drv_high = drive_pct > DRIVE_HIGH_PCT;
  wire tvl_above = travel_pct > TRAVEL_LOW_PCT;
  wire tvl_below = travel_pct < TRAVEL_HIGH_PCT;
  wire drive_closed = (drv_low && tvl_above) ||
                      (drv_high && tvl_below);
  wire drive_open = (drv_low && tvl_below) ||
                    (drv_high && tvl_above);
  wire drive_cond = zp_open ? drive_open : drive_closed;

  // ==========================================================
  // alert gating and shutdown
  wire [5:0] raw_cond = {fault_s2_ff[3],
                         fault_s2_ff[2],
                         fault_s2_ff[1],
                         fault_s2_ff[0],
                         drive_cond, mismatch_ff};
  wire [5:0] alerts = raw_cond & alert_en_ff;
  wire shut_cause = trigger_en && |(alerts & SHUTDOWN_MASK);

  vfm_state_type state_ff;
  vfm_state_type nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (shut_cause) nxt_state = ST_SHUT_AUTO;
      end
      ST_SHUT_AUTO: begin
        if (shut_cause) nxt_state = ST_SHUT_AUTO;
        else if (auto_recover) nxt_state = ST_RUN;
        else nxt_state = ST_SHUT_LATCH;
      end
      ST_SHUT_LATCH: begin
        if (shut_cause) nxt_state = ST_SHUT_AUTO;
        else if (target_wr_ff) nxt_state = ST_RUN;
      end
      default: nxt_state = ST_RUN;
    endcase
  end

  logic shut_ff;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_ff <= ST_RUN;
      shut_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      shut_ff <= (nxt_state != ST_RUN);
    end
  end

  assign zero_power_cmd = shut_ff;
  assign control_run = !shut_ff;
  assign actual_mode = shut_ff ? MODE_OOS : target_ff;

  // ==========================================================
  // plant alert notification with retransmit
  vfm_notify_type nstate_ff;
  logic [15:0] ncount_ff;
  logic [5:0] pend_ff;
  logic [5:0] sent_ff;
  logic nvalid_ff;
  logic [5:0] alerts_d_ff;
  wire [5:0] new_alerts = alerts & ~alerts_d_ff;
  wire [5:0] nxt_pend = new_alerts | (pend_ff & ~(notify_ack ?
                        sent_ff : 6'h00));
  // retransmit does not look at current condition on purpose
  wire send_now = (nstate_ff == NT_IDLE) && |pend_ff;
  // ack wins over a retransmit falling due in the same cycle
  wire expired = (nstate_ff == NT_WAIT) && !notify_ack &&
                 (ncount_ff >= timeout_ff);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      nstate_ff <= NT_IDLE;
      ncount_ff <= 16'h0000;
      pend_ff <= 6'h00;
      sent_ff <= 6'h00;
      nvalid_ff <= 1'b0;
      alerts_d_ff <= 6'h00;
    end else begin
      alerts_d_ff <= alerts;
      pend_ff <= nxt_pend;
      nvalid_ff <= send_now || expired;
      case (nstate_ff)
        NT_IDLE: begin
          ncount_ff <= 16'h0000;
          if (send_now) begin
            sent_ff <= pend_ff;
            nstate_ff <= NT_WAIT;
          end
        end
        NT_WAIT: begin
          if (notify_ack) begin
            nstate_ff <= NT_IDLE;
          end else if (expired) begin
            ncount_ff <= 16'h0000;
          end else begin
            ncount_ff <= 16'(ncount_ff + 1'b1);
          end
        end
        default: nstate_ff <= NT_IDLE;
      endcase
    end
  end
  assign notify_valid = nvalid_ff;
  assign notify_alerts = sent_ff;
  assign notify_category = cat_ff;

  // ==========================================================
  // interrupt status, set wins over clear
  wire [5:0] clr_bits = wr_clr ? reg_wdata[5:0] : 6'h00;
  always_ff @(posedge mclk) begin
    if (!resetn) irq_stat_ff <= 6'h00;
    else irq_stat_ff <= alerts | (irq_stat_ff & ~clr_bits);
  end
  assign irq = |(irq_stat_ff & irq_en_ff);

  // ==========================================================
  // read mux
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      ADDR_CTRL: rd_mux = {29'h0, ctrl_ff};
      ADDR_MISMATCH_THR: rd_mux = {24'h0, thr_ff};
      ADDR_MISMATCH_TIME: rd_mux = 32'(mtime_ff);
      ADDR_ALERT_EN: rd_mux = {26'h0, alert_en_ff};
      ADDR_ALERT_STAT: rd_mux = {26'h0, alerts};
      ADDR_IRQ_STAT: rd_mux = {26'h0, irq_stat_ff};
      ADDR_IRQ_EN: rd_mux = {26'h0, irq_en_ff};
      ADDR_TARGET_MODE: rd_mux = {30'h0, target_ff};
      ADDR_MODE_STAT: rd_mux = {29'h0, shut_ff, actual_mode};
      ADDR_CATEGORY: rd_mux = {20'h0, cat_ff};
      ADDR_NOTIFY_TIMEOUT: rd_mux = {16'h0, timeout_ff};
      ADDR_MEASURE: rd_mux = {8'h0, travel_pct, coil_pct,
                              drive_pct};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!resetn) rdata_ff <= 32'h0000_0000;
    else rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
  end
  assign reg_rdata = rdata_ff;

endmodule // vfm_monitor

// ==== testbench/vfm_valve_model.sv ====
// Purpose: converter coil and valve travel seen by the fault monitor
// Assumes: coil and travel settle one clock after the command
// Notes: the bench injects coil error and a stuck travel on purpose
`timescale 1ns/100ps
module vfm_valve_model (
  input wire logic mclk, // clock
  input wire logic [7:0] drive_pct, // commanded drive, percent
  input wire logic [7:0] coil_off, // coil error chosen by the bench
  input wire logic [7:0] travel_set, // travel the valve settles at
  output logic [7:0] coil_pct, // measured coil current, percent
  output logic [7:0] travel_pct // calibrated travel, percent
);
  // =====
  // coil follows drive in the same percent scale
  always_ff @(posedge mclk) begin
    coil_pct <= drive_pct + coil_off;
    travel_pct <= travel_set;
  end
endmodule // vfm_valve_model

// ==== testbench/vfm_monitor_chk.sv ====
// Purpose: port-level checks of the fault monitor
// Assumes: one clock domain, synchronous active-low reset
// Notes: register contents are not visible, so checks stay at the ports
`timescale 1ns/100ps
module vfm_monitor_chk
  import vfm_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic resetn, // reset, active low
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [31:0] reg_rdata, // read data
  input wire logic zero_power_cmd, // shutdown drive
  input wire logic control_run, // control running
  input wire logic [1:0] actual_mode, // actual mode
  input wire logic notify_valid, // notification pulse
  input wire logic [11:0] notify_category, // categories
  input wire logic irq // interrupt
);
  // =====
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_run_inverse: assert property (control_run == !zero_power_cmd)
    else $error("control runs while driving to zero power");
  a_shut_oos: assert property (
    zero_power_cmd |-> actual_mode == MODE_OOS)
    else $error("shut down but mode not out of service");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside the answer cycle");
  a_mode_legal: assert property (actual_mode != 2'h3)
    else $error("illegal actual mode");
  a_reset_vals: assert property ($rose(resetn) |-> !zero_power_cmd
    && actual_mode == MODE_AUTO && !notify_valid && !irq)
    else $error("outputs wrong after reset");
  // without a write or shutdown edge the mode must not move
  a_mode_stable: assert property (
    !zero_power_cmd && $past(!zero_power_cmd) && !$past(reg_wr)
    && !$past(reg_wr, 2) |-> $stable(actual_mode))
    else $error("mode changed with no cause");
  a_notify_pulse: assert property (notify_valid |=> !notify_valid)
    else $error("notification longer than one cycle");
  a_cat_stable: assert property (
    !$past(reg_wr) |-> $stable(notify_category))
    else $error("category changed without a write");
endmodule // vfm_monitor_chk
bind vfm_monitor vfm_monitor_chk u_chk (.mclk(mclk), .resetn(resetn),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .zero_power_cmd(zero_power_cmd), .control_run(control_run),
  .actual_mode(actual_mode), .notify_valid(notify_valid),
  .notify_category(notify_category), .irq(irq));

// ==== testbench/valve_fault_monitor_shutdown_tb.sv ====
// Purpose: self-checking bench for the valve fault monitor
// Assumes: short mismatch time and notify timeout set by register
// Notes: drive-level cases run from a table, the rest by hand
`timescale 1ns/100ps
module valve_fault_monitor_shutdown_tb;
  import vfm_pkg::*;
  logic mclk, resetn, reg_wr, reg_rd, nv, ack, irq, zp, run;
  logic [3:0] reg_addr, fails;
  logic [31:0] reg_wdata, reg_rdata;
  logic [7:0] drive, coil_off, travel_set, coil, travel;
  logic [1:0] mode;
  logic [5:0] nal;
  logic [11:0] ncat;
  int err_total, n_checks, cycles, c;
  // {expect, zero power open, drive, travel}
  logic [17:0] rows [11] = '{18'h20904, 18'h00A04, 18'h00903, 18'h25B60,
    18'h05A60, 18'h05B61, 18'h30960, 18'h10961, 18'h35B04, 18'h15B03,
    18'h10A32};
  // =====
  vfm_monitor DUT (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .drive_pct(drive), .coil_pct(coil),
    .travel_pct(travel), .prog_mem_fail(fails[0]),
    .static_mem_fail(fails[1]), .proc_fail(fails[2]),
    .io_proc_fail(fails[3]), .zero_power_cmd(zp), .control_run(run),
    .actual_mode(mode), .notify_valid(nv), .notify_alerts(nal),
    .notify_category(ncat), .notify_ack(ack), .irq(irq));
  vfm_valve_model u_valve (.mclk(mclk), .drive_pct(drive),
    .coil_off(coil_off), .travel_set(travel_set), .coil_pct(coil),
    .travel_pct(travel));
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      end_of_test;
    end
  end
  // =====
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  // data stands only in the cycle after the strobe
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
    @(posedge mclk);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic irqchk(input logic e);
    @(negedge mclk);
    chk(irq, e);
    @(posedge mclk);
  endtask
  task automatic wn(input int lim);
    c = 0;
    do begin
      @(negedge mclk);
      c++;
    end while (nv !== 1'b1 && c < lim);
    @(posedge mclk);
  endtask
  task end_of_test;
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // =====
  initial begin
    mclk = 0; resetn = 0; reg_addr = 0; reg_wdata = 0; reg_wr = 0;
    reg_rd = 0; drive = 8'h32; coil_off = 0; travel_set = 8'h32;
    fails = 0; ack = 0; err_total = 0; n_checks = 0; cycles = 0;
    cyc(2);
    resetn <= 1'b1;
    cyc(1);
    rc(ADDR_CTRL, 32'(CTRL_RESET));
    rc(ADDR_MISMATCH_THR, 32'(THR_RESET));
    rc(ADDR_ALERT_EN, 32'(ALERT_EN_RESET));
    rc(ADDR_MODE_STAT, 32'h2);
    rc(4'hD, 32'h0);
    rc(ADDR_MEASURE, 32'h0032_3232);
    for (int i = 0; i < 11; i++) begin
      wr(ADDR_CTRL, {29'h0, rows[i][16], 2'b00});
      drive <= rows[i][15:8];
      travel_set <= rows[i][7:0];
      cyc(4);
      rc(ADDR_ALERT_STAT, {30'h0, rows[i][17], 1'b0});
    end
    drive <= 8'h32;
    travel_set <= 8'h32;
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_MISMATCH_TIME, 32'h8);
    coil_off <= 8'h06;
    cyc(4);
    rc(ADDR_ALERT_STAT, 32'h0);
    coil_off <= 8'h05;
    cyc(3);
    coil_off <= 8'h06;
    cyc(6);
    rc(ADDR_ALERT_STAT, 32'h0);
    cyc(10);
    rc(ADDR_ALERT_STAT, 32'h1);
    rc(ADDR_MODE_STAT, 32'h4);
    chk(zp, 1'b1);
    chk(run, 1'b0);
    chk(mode, 2'h0);
    coil_off <= 8'h00;
    cyc(10);
    rc(ADDR_MODE_STAT, 32'h4);
    wr(ADDR_TARGET_MODE, 32'h1);
    cyc(3);
    rc(ADDR_MODE_STAT, 32'h1);
    wr(ADDR_CTRL, 32'h3);
    for (int k = 0; k < 4; k++) begin
      fails[k] <= 1'b1;
      cyc(8);
      rc(ADDR_ALERT_STAT, 32'h4 << k);
      rc(ADDR_MODE_STAT, (k == 2) ? 32'h1 : 32'h4);
      fails[k] <= 1'b0;
      cyc(8);
      rc(ADDR_MODE_STAT, 32'h1);
    end
    fails[3] <= 1'b1;
    cyc(30);
    rc(ADDR_MODE_STAT, 32'h4);
    wr(ADDR_CTRL, 32'h2);
    cyc(4);
    rc(ADDR_MODE_STAT, 32'h1);
    wr(ADDR_ALERT_EN, 32'h1F);
    cyc(3);
    rc(ADDR_ALERT_STAT, 32'h0);
    fails[3] <= 1'b0;
    resetn <= 1'b0;
    cyc(2);
    resetn <= 1'b1;
    cyc(1);
    wr(ADDR_NOTIFY_TIMEOUT, 32'd20);
    wr(ADDR_IRQ_EN, 32'h3F);
    wr(ADDR_CATEGORY, 32'h918);
    chk(ncat, 12'h918);
    fails[3] <= 1'b1;
    wn(10);
    chk(c < 10, 1'b1);
    chk(nal, 6'h20);
    fails[3] <= 1'b0;
    wn(40);
    chk(c >= 18 && c <= 24, 1'b1);
    ack <= 1'b1;
    @(posedge mclk);
    ack <= 1'b0;
    wn(60);
    chk(c, 60);
    irqchk(1'b1);
    wr(ADDR_IRQ_EN, 32'h0);
    irqchk(1'b0);
    wr(ADDR_IRQ_EN, 32'h3F);
    irqchk(1'b1);
    wr(ADDR_IRQ_CLR, 32'h3F);
    irqchk(1'b0);
    end_of_test;
  end
endmodule // valve_fault_monitor_shutdown_tb
